// ==== common/sar_adc_consts.vh ====
// constants for the converter sequencing and serial readout block
// assumes inclusion by bare name from the design files
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
`define RESULT_BITS 16
`define DATA_BITS 14
`define BIT_CNT_W 5
`define ACQ_WAIT 3
`define ACQ_CNT_W 2
`define CAL_CYCLES 14000
`define CAL_CNT_W 16
`define FIFO_DEPTH 4
`define FIFO_ADDR_W 2
`define SYNC_WIDTH 8
`define TRIAL_MSB 16'h8000
`endif

// ==== src/pin_sync.v ====
// two-stage synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk_in
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 8
) (
   input wire clk_in,
   input wire reset_in,
   input wire [WIDTH-1:0] pins_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge clk_in) begin
      if (reset_in) begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q <= pins_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== src/result_fifo.v ====
// small first-in first-out store for conversion results
// assumes both sides on clk_in; depth is a power of two
`timescale 1ns/1ps
module result_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 4,
   parameter ADDR_W = 2
) (
   input wire clk_in,
   input wire reset_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [ADDR_W:0] wr_q;
   reg [ADDR_W:0] rd_q;
   wire full;
   wire empty;
   wire push;
   wire pop;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[ADDR_W] != rd_q[ADDR_W]) && (wr_q[ADDR_W-1:0] == rd_q[ADDR_W-1:0]);
   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem_q[rd_q[ADDR_W-1:0]];
   assign push = in_valid_in & ~full;
   assign pop = out_ready_in & ~empty;

   always @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_q[ADDR_W-1:0]] <= in_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (reset_in) begin
         wr_q <= {(ADDR_W+1){1'b0}};
         rd_q <= {(ADDR_W+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{ADDR_W{1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{ADDR_W{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ==== src/sar_adc_serial_readout.v ====
// conversion sequencing, calibration timing and serial result readout
// assumes all pin inputs asynchronous to clk_in, which is much faster than
// both the conversion clock and the readout clock
`timescale 1ns/1ps
`include "sar_adc_consts.vh"

// Contract
// - result leaves msb first, fourteen then two
// - serial output driven only while chip select low
// - done signal high exactly while bits shift; the code also holds it high through halt and calibration
// - start on falling clock after request, acquisition
// - conversion read bits change on falling clock
// - msb appears when select falls, before clocks
// - each readout clock fall advances one bit
// - fifteenth readout pulse shows final sub-lsb
// - pulses beyond sixteen bits shift out zeros
// - between-conversion output changes on readout falls only
// - falling done marks conversion end
// - new start right after minimum four-cycle acquisition
// - start after three idle cycles, else fourth
// - further convert requests ignored while converting
// - low reset pin halts, rise starts calibration
// - three-level pin selects bipolar, unipolar, shutdown
module sar_adc_serial_readout #(
   parameter [`CAL_CNT_W-1:0] CAL_CYCLES = `CAL_CYCLES,
   parameter DEPTH = `FIFO_DEPTH,
   parameter ADDR_W = `FIFO_ADDR_W
) (
   input wire clk_in,
   input wire reset_in,
   input wire convert_start_n_clk_in,
   input wire convert_start_n_in,
   input wire chip_select_n_in,
   input wire readout_clock_in,
   input wire reset_pin_n_in,
   input wire range_driven_in,
   input wire range_level_in,
   input wire comparator_in,
   output reg serial_data_out,
   output reg serial_data_oe_out,
   output reg conversion_done_n_out,
   output reg track_out,
   output reg [`RESULT_BITS-1:0] dac_trial_out,
   output reg bipolar_out,
   output reg shutdown_out,
   output reg calibrating_out
);
   localparam [1:0] ST_HALT = 2'b00;
   localparam [1:0] ST_CAL = 2'b01;
   localparam [1:0] ST_IDLE = 2'b10;
   localparam [1:0] ST_CONVERT_START_N = 2'b11;
   localparam [`BIT_CNT_W-1:0] LAST_BIT = `RESULT_BITS;
   localparam [`ACQ_CNT_W-1:0] ACQ_WAIT = `ACQ_WAIT;
   localparam [`CAL_CNT_W-1:0] CAL_LAST = CAL_CYCLES - {{(`CAL_CNT_W-1){1'b0}}, 1'b1};
   localparam [`RESULT_BITS-1:0] TRIAL_MSB = `TRIAL_MSB;

   wire [`SYNC_WIDTH-1:0] sync_bus;
   wire convert_start_n_clk_s;
   wire convert_start_n_s;
   wire chip_select_n_s;
   wire readout_clock_s;
   wire reset_pin_n_s;
   wire range_driven_s;
   wire range_level_s;
   wire comparator_s;

   reg [1:0] state_q;
   reg convert_start_n_clk_q;
   reg chip_select_n_q;
   reg readout_clock_q;
   reg [`ACQ_CNT_W-1:0] acq_q;
   reg [`CAL_CNT_W-1:0] cal_cnt_q;
   reg [`BIT_CNT_W-1:0] bit_cnt_q;
   reg [`RESULT_BITS-1:0] sar_q;
   reg convert_start_n_bit_q;
   reg pending_q;
   reg read_live_q;
   reg push_q;
   reg [`RESULT_BITS-1:0] shift_q;
   reg [`RESULT_BITS-1:0] last_q;
   reg [1:0] settle_q;

   wire convert_start_n_fall;
   wire cs_fall;
   wire readout_fall;
   wire converting;
   wire select_ok;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [`RESULT_BITS-1:0] fifo_out_data;
   wire pop;
   wire start_ok;
   wire decided_bit;
   wire [`RESULT_BITS-1:0] bit_mask;
   wire [`RESULT_BITS-1:0] sar_next;
   wire [`BIT_CNT_W-1:0] bit_cnt_inc;
   reg serial_d;

   pin_sync #(
      .WIDTH(`SYNC_WIDTH)
   ) u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pins_in({convert_start_n_clk_in, convert_start_n_in, chip_select_n_in, readout_clock_in,
                reset_pin_n_in, range_driven_in, range_level_in, comparator_in}),
      .sync_out(sync_bus)
   );

   assign convert_start_n_clk_s = sync_bus[7];
   assign convert_start_n_s = sync_bus[6];
   assign chip_select_n_s = sync_bus[5];
   assign readout_clock_s = sync_bus[4];
   assign reset_pin_n_s = sync_bus[3];
   assign range_driven_s = sync_bus[2];
   assign range_level_s = sync_bus[1];
   assign comparator_s = sync_bus[0];

   // edges seen on the synchronised copies only
   assign convert_start_n_fall = convert_start_n_clk_q & ~convert_start_n_clk_s;
   assign readout_fall = readout_clock_q & ~readout_clock_s;
   // select is trusted only once the synchroniser has flushed its reset zeros
   assign select_ok = settle_q[1];
   assign cs_fall = select_ok & chip_select_n_q & ~chip_select_n_s;
   assign converting = (state_q == ST_CONVERT_START_N);

   // a low comparator means the trial weight fits, so the bit is set
   assign decided_bit = ~comparator_s;
   assign bit_mask = TRIAL_MSB >> bit_cnt_q;
   assign sar_next = decided_bit ? (sar_q | bit_mask) : sar_q;
   assign bit_cnt_inc = bit_cnt_q + {{(`BIT_CNT_W-1){1'b0}}, 1'b1};

   // a full store stalls new starts rather than drop an unread result
   assign start_ok = pending_q & fifo_in_ready & ~shutdown_out;

   // a between-conversion read takes the oldest unread result
   assign pop = cs_fall & ~converting & fifo_out_valid;

   result_fifo #(
      .WIDTH(`RESULT_BITS),
      .DEPTH(DEPTH),
      .ADDR_W(ADDR_W)
   ) u_fifo (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .in_valid_in(push_q),
      .in_ready_out(fifo_in_ready),
      .in_data_in(sar_q),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(pop),
      .out_data_out(fifo_out_data)
   );

   always @(posedge clk_in) begin
      if (reset_in) begin
         convert_start_n_clk_q <= 1'b0;
         chip_select_n_q <= 1'b1;
         readout_clock_q <= 1'b0;
      end else begin
         convert_start_n_clk_q <= convert_start_n_clk_s;
         chip_select_n_q <= select_ok ? chip_select_n_s : 1'b1;
         readout_clock_q <= readout_clock_s;
      end
   end

   // reset zeros in the synchroniser would otherwise look like a select fall
   // and switch the output on while select is still high
   always @(posedge clk_in) begin
      if (reset_in) begin
         settle_q <= 2'h0;
      end else begin
         settle_q <= {settle_q[0], 1'b1};
      end
   end

   always @(posedge clk_in) begin
      if (reset_in) begin
         bipolar_out <= 1'b1;
         shutdown_out <= 1'b0;
      end else begin
         bipolar_out <= ~range_driven_s;
         shutdown_out <= range_driven_s & ~range_level_s;
      end
   end

   // conversion request is a level synchronous to the conversion clock
   always @(posedge clk_in) begin
      if (reset_in) begin
         pending_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         if (convert_start_n_fall && start_ok && acq_q == ACQ_WAIT) begin
            pending_q <= 1'b0;
         end else if (!convert_start_n_s) begin
            pending_q <= 1'b1;
         end
      end else begin
         pending_q <= 1'b0;
      end
   end

   always @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= ST_HALT;
         acq_q <= {`ACQ_CNT_W{1'b0}};
         cal_cnt_q <= {`CAL_CNT_W{1'b0}};
         bit_cnt_q <= {`BIT_CNT_W{1'b0}};
         sar_q <= {`RESULT_BITS{1'b0}};
         convert_start_n_bit_q <= 1'b0;
         read_live_q <= 1'b0;
         push_q <= 1'b0;
         conversion_done_n_out <= 1'b1;
         track_out <= 1'b0;
         dac_trial_out <= {`RESULT_BITS{1'b0}};
         calibrating_out <= 1'b0;
      end else begin
         push_q <= 1'b0;
         if (chip_select_n_s) begin
            read_live_q <= 1'b0;
         end
         if (!reset_pin_n_s) begin
            // low reset pin holds the sequencer in halt until it rises; readout and range decode keep running
            state_q <= ST_HALT;
            conversion_done_n_out <= 1'b1;
            calibrating_out <= 1'b0;
            track_out <= 1'b0;
         end else begin
            case (state_q)
               ST_HALT: begin
                  state_q <= ST_CAL;
                  cal_cnt_q <= {`CAL_CNT_W{1'b0}};
                  calibrating_out <= 1'b1;
                  conversion_done_n_out <= 1'b1;
               end
               ST_CAL: begin
                  if (convert_start_n_fall) begin
                     if (cal_cnt_q == CAL_LAST) begin
                        state_q <= ST_IDLE;
                        calibrating_out <= 1'b0;
                        conversion_done_n_out <= 1'b0;
                        acq_q <= ACQ_WAIT;
                        track_out <= 1'b1;
                     end else begin
                        cal_cnt_q <= cal_cnt_q + {{(`CAL_CNT_W-1){1'b0}}, 1'b1};
                     end
                  end
               end
               ST_IDLE: begin
                  if (convert_start_n_fall) begin
                     // acquisition spans at least four conversion clocks, except the first start after calibration
                     if (start_ok && acq_q == ACQ_WAIT) begin
                        state_q <= ST_CONVERT_START_N;
                        bit_cnt_q <= {`BIT_CNT_W{1'b0}};
                        sar_q <= {`RESULT_BITS{1'b0}};
                        dac_trial_out <= TRIAL_MSB;
                        track_out <= 1'b0;
                        read_live_q <= ~chip_select_n_s;
                     end else if (acq_q != ACQ_WAIT) begin
                        acq_q <= acq_q + {{(`ACQ_CNT_W-1){1'b0}}, 1'b1};
                     end
                  end
               end
               ST_CONVERT_START_N: begin
                  if (convert_start_n_fall) begin
                     if (bit_cnt_q != LAST_BIT) begin
                        // one bit per falling edge, done held high meanwhile
                        conversion_done_n_out <= 1'b1;
                        convert_start_n_bit_q <= decided_bit;
                        sar_q <= sar_next;
                        dac_trial_out <= sar_next | (bit_mask >> 1);
                        bit_cnt_q <= bit_cnt_inc;
                     end else begin
                        state_q <= ST_IDLE;
                        conversion_done_n_out <= 1'b0;
                        acq_q <= {`ACQ_CNT_W{1'b0}};
                        track_out <= 1'b1;
                        dac_trial_out <= {`RESULT_BITS{1'b0}};
                        // a result already read live is not queued again
                        push_q <= ~read_live_q;
                     end
                  end
               end
               default: begin
                  state_q <= ST_HALT;
               end
            endcase
         end
      end
   end

   // between-conversion shifter; holds the last word if nothing is queued
   always @(posedge clk_in) begin
      if (reset_in) begin
         shift_q <= {`RESULT_BITS{1'b0}};
         last_q <= {`RESULT_BITS{1'b0}};
      end else if (!converting) begin
         if (cs_fall) begin
            if (fifo_out_valid) begin
               shift_q <= fifo_out_data;
               last_q <= fifo_out_data;
            end else begin
               shift_q <= last_q;
            end
         end else if (!chip_select_n_s && readout_fall) begin
            // zero fill makes extra pulses read as zero
            shift_q <= {shift_q[`RESULT_BITS-2:0], 1'b0};
         end
      end else if (read_live_q) begin
         // every bit already left live, so later readout pulses give zeros
         shift_q <= {`RESULT_BITS{1'b0}};
      end
   end

   always @* begin
      if (converting) begin
         serial_d = convert_start_n_bit_q;
      end else if (cs_fall) begin
         serial_d = fifo_out_valid ? fifo_out_data[`RESULT_BITS-1] : last_q[`RESULT_BITS-1];
      end else if (!chip_select_n_s && readout_fall) begin
         serial_d = shift_q[`RESULT_BITS-2];
      end else begin
         serial_d = shift_q[`RESULT_BITS-1];
      end
   end

   // output lags select by the synchroniser, not a combinational path
   always @(posedge clk_in) begin
      if (reset_in) begin
         serial_data_out <= 1'b0;
         serial_data_oe_out <= 1'b0;
      end else begin
         serial_data_out <= serial_d;
         // kept off until the select synchroniser holds a real pin level
         serial_data_oe_out <= select_ok & ~chip_select_n_s;
      end
   end
endmodule

// ==== tb/host_far_model.sv ====
// host and comparator model facing the serial pins
// assumes driving on falling clk_in edges; clocks idle low
`timescale 1ns/1ps
module host_far_model (
   input wire logic clk_in,
   input wire logic serial_data_in,
   input wire logic serial_data_oe_in,
   input wire logic conversion_done_n_in,
   input wire logic track_in,
   output logic convert_start_n_clk_out,
   output logic readout_clock_out,
   output logic chip_select_n_out,
   output logic convert_start_n_out,
   output logic comparator_out,
   output logic rx_valid_out,
   output logic [15:0] rx_word_out
);
   logic last_q = 1'b0;
   logic pin;
   logic [15:0] word_q;
   integer dec = 0;
   // released line must not show a stale bit
   always @(posedge clk_in) if (serial_data_oe_in) last_q <= serial_data_in;
   assign pin = serial_data_oe_in ? serial_data_in : ~last_q;
   initial begin
      {convert_start_n_clk_out, readout_clock_out, rx_valid_out, rx_word_out} = 19'h0;
      {chip_select_n_out, convert_start_n_out, comparator_out} = 3'h7;
   end
   task wait_clk(input integer n); repeat (n) @(negedge clk_in); endtask
   task emit; rx_word_out = word_q; rx_valid_out = 1'b1; wait_clk(1); rx_valid_out = 1'b0; endtask
   task tick(input logic [15:0] w, input logic live);
      convert_start_n_clk_out = 1'b1;
      if (!track_in && dec < 16) begin
         comparator_out = ~w[15 - dec]; // low keeps the trial bit
         dec = dec + 1;
      end
      if (live && conversion_done_n_in) word_q = {word_q[14:0], pin};
      wait_clk(8);
      convert_start_n_clk_out = 1'b0;
      wait_clk(8);
   endtask
   task convert_start_n_run(input logic [15:0] w, input integer idle, input logic live, output integer starts);
      integer n;
      chip_select_n_out = ~live;
      repeat (idle) tick(w, 1'b0);
      dec = 0;
      word_q = 16'h0;
      starts = 99;
      convert_start_n_out = 1'b0;
      for (n = 1; n <= 8 && starts == 99; n++) begin
         tick(w, live);
         if (!track_in) starts = n;
      end
      convert_start_n_out = 1'b1;
      if (starts != 99) begin
         for (n = 0; n < 20 && (n < 2 || conversion_done_n_in); n++) begin
            convert_start_n_out = (n != 5);
            tick(w, live);
         end
         if (live) emit;
      end
      convert_start_n_out = 1'b1;
      chip_select_n_out = 1'b1;
   endtask
   // capture just before each fall, as allowed above 2.5MHz
   task read_between(output logic [1:0] tail);
      integer j;
      chip_select_n_out = 1'b0;
      wait_clk(6);
      for (j = 0; j < 18; j++) begin
         readout_clock_out = 1'b1;
         wait_clk(4);
         if (j < 16) word_q = {word_q[14:0], pin};
         else tail[j - 16] = pin;
         readout_clock_out = 1'b0;
         wait_clk(4);
      end
      chip_select_n_out = 1'b1;
      emit;
      wait_clk(50);
   endtask
endmodule

// ==== tb/sar_adc_props.sv ====
// checker for the converter sequencing and readout block
// assumes bench clocks far slower than clk_in; bound at file foot
`timescale 1ns/1ps
module sar_adc_props #(parameter CAL_CYCLES = 20, parameter DEPTH = 4, parameter ADDR_W = 2) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic convert_start_n_clk_in,
   input wire logic convert_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic readout_clock_in,
   input wire logic reset_pin_n_in,
   input wire logic range_driven_in,
   input wire logic range_level_in,
   input wire logic comparator_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe_out,
   input wire logic conversion_done_n_out,
   input wire logic track_out,
   input wire logic [15:0] dac_trial_out,
   input wire logic bipolar_out,
   input wire logic shutdown_out,
   input wire logic calibrating_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic ro_q;
   logic [3:0] gap_q;
   // cycles since a raw readout fall, saturating
   always_ff @(posedge clk_in) begin
      ro_q <= readout_clock_in;
      if (reset_in) gap_q <= 4'hF;
      else if (ro_q && !readout_clock_in) gap_q <= 4'h0;
      else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
   end
   property p_hiz; chip_select_n_in [*4] |-> !serial_data_oe_out; endproperty
   a_hiz: assert property (p_hiz) else $error("output driven with select high");
   property p_drive; !chip_select_n_in [*4] |-> serial_data_oe_out; endproperty
   a_drive: assert property (p_drive) else $error("output released with select low");
   property p_quiet; $fell(reset_in) && chip_select_n_in |-> !serial_data_oe_out [*3]; endproperty
   a_quiet: assert property (p_quiet) else $error("output driven just after reset");
   property p_start; $fell(track_out) && reset_pin_n_in |-> dac_trial_out == 16'h8000 && !conversion_done_n_out;
   endproperty
   a_start: assert property (p_start) else $error("bad state at conversion start");
   property p_first; $fell(track_out) && reset_pin_n_in |-> ##[1:40] $rose(conversion_done_n_out); endproperty
   a_first: assert property (p_first) else $error("done not raised after start");
   property p_hold;
      track_out && $past(track_out, 4) && $past(serial_data_oe_out, 3) && $changed(serial_data_out) |-> gap_q <= 4'h6;
   endproperty
   a_hold: assert property (p_hold) else $error("data moved without readout fall");
   property p_end; $fell(conversion_done_n_out) |-> ##[0:1] track_out; endproperty
   a_end: assert property (p_end) else $error("done fell without acquisition");
   property p_halt; !reset_pin_n_in [*4] |-> !calibrating_out; endproperty
   a_halt: assert property (p_halt) else $error("calibrating while halted");
   property p_cal; $rose(reset_pin_n_in) |-> ##[1:6] calibrating_out; endproperty
   a_cal: assert property (p_cal) else $error("no calibration after pin rise");
   property p_range;
      $stable({range_driven_in, range_level_in}) [*4] |->
         bipolar_out == !range_driven_in && shutdown_out == (range_driven_in && !range_level_in);
   endproperty
   a_range: assert property (p_range) else $error("range mode mismatch");
   c_start: cover property ($fell(track_out));
   c_end: cover property ($fell(conversion_done_n_out));
   c_live: cover property (serial_data_oe_out && !track_out);
endmodule
bind sar_adc_serial_readout sar_adc_props #(.CAL_CYCLES(CAL_CYCLES), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_props (
   .clk_in(clk_in), .reset_in(reset_in), .convert_start_n_clk_in(convert_start_n_clk_in), .convert_start_n_in(convert_start_n_in),
   .chip_select_n_in(chip_select_n_in), .readout_clock_in(readout_clock_in), .reset_pin_n_in(reset_pin_n_in),
   .range_driven_in(range_driven_in), .range_level_in(range_level_in), .comparator_in(comparator_in),
   .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
   .conversion_done_n_out(conversion_done_n_out), .track_out(track_out), .dac_trial_out(dac_trial_out),
   .bipolar_out(bipolar_out), .shutdown_out(shutdown_out), .calibrating_out(calibrating_out));

// ==== tb/sar_adc_serial_readout_tb_top.sv ====
// bench top: reset, calibration, queued and live conversions
// assumes the far side model drives all link pins
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top;
   logic clk_in = 1'b0, reset_in = 1'b1, reset_pin_n_in = 1'b1, range_driven_in = 1'b0, range_level_in = 1'b0;
   wire sdo, soe, done_n, trk, bip, shd, cal, cclk, rclk, cs_n, cnv_n, comp, rx_v;
   wire [15:0] trial, rx_w;
   integer failures = 0, checked = 0;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'h1;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   initial forever #10 clk_in = ~clk_in;
   sar_adc_serial_readout #(.CAL_CYCLES(16'h14)) uut (.clk_in(clk_in), .reset_in(reset_in), .convert_start_n_clk_in(cclk),
      .convert_start_n_in(cnv_n), .chip_select_n_in(cs_n), .readout_clock_in(rclk), .reset_pin_n_in(reset_pin_n_in),
      .range_driven_in(range_driven_in), .range_level_in(range_level_in), .comparator_in(comp),
      .serial_data_out(sdo), .serial_data_oe_out(soe), .conversion_done_n_out(done_n), .track_out(trk),
      .dac_trial_out(trial), .bipolar_out(bip), .shutdown_out(shd), .calibrating_out(cal));
   host_far_model host (.clk_in(clk_in), .serial_data_in(sdo), .serial_data_oe_in(soe),
      .conversion_done_n_in(done_n), .track_in(trk), .convert_start_n_clk_out(cclk), .readout_clock_out(rclk),
      .chip_select_n_out(cs_n), .convert_start_n_out(cnv_n), .comparator_out(comp), .rx_valid_out(rx_v),
      .rx_word_out(rx_w));
   task check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task print_verdict;
      if (failures == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      if (rx_v && exp_q.size() == 0) begin
         failures++;
         $display("BAD %0t unexpected word", $time);
      end
      else if (rx_v) check(rx_w, exp_q.pop_front());
   end
   initial begin
      #500000;
      failures++;
      print_verdict;
   end
   initial begin
      integer i, k, st;
      logic [15:0] w[5];
      logic [1:0] tl;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in) reset_in = 1'b0;
      for (i = 0; i < 4; i++) begin
         range_driven_in = i[0];
         range_level_in = i[1];
         host.wait_clk(5);
         check({bip, shd}, {~i[0], i[0] & ~i[1]});
      end
      for (k = 0; k < 2; k++) begin
         if (k == 1) begin
            reset_pin_n_in = 1'b0;
            host.wait_clk(8);
            reset_pin_n_in = 1'b1;
            host.wait_clk(8);
         end
         repeat (19) host.tick(16'h0, 1'b0);
         check({cal, done_n}, 2'h3);
         repeat (2) host.tick(16'h0, 1'b0);
         check({cal, done_n}, 2'h0);
      end
      // four queued results fill the store, the fifth start waits
      for (i = 0; i < 5; i++) begin
         seed = xs(seed);
         w[i] = seed[15:0];
         host.convert_start_n_run(w[i], (i == 0) ? 0 : i - 1, 1'b0, st);
         check(st[15:0], (i == 4) ? 16'h63 : (i == 0) ? 16'h1 : 16'h5 - i[15:0]);
      end
      for (i = 0; i < 4; i++) begin
         exp_q.push_back(w[i]);
         host.read_between(tl);
         check(tl, 2'h0);
      end
      seed = xs(seed);
      w[4] = seed[15:0];
      exp_q.push_back(w[4]);
      host.convert_start_n_run(w[4], 0, 1'b1, st);
      check(st[15:0], 16'h1);
      repeat (5) host.tick(16'h0, 1'b0);
      check({trk, done_n}, 2'h2);
      host.wait_clk(20);
      check(exp_q.size(), 16'h0);
      print_verdict;
   end
endmodule
